// ---- logic/dtc_debug_ctl.sv ----
// Debug entry and trace control: entry causes, trace countdown, status and test port registers.
// Assumes test pins are asynchronous and core strobes are one-cycle pulses on clk.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Each executed instruction decrements countdown after release
// - Countdown expiry requests debug and sets flag
// - Count one gives two instructions; zero needs sequential
// - Executing at zero count enters debug mode
// - Aborted instructions neither count nor enter debug
// - Mode field reports debug mode
// - Debug request at reset halts before execution
// - Running request halts after next fetch latches
// - Low-power request wakes, then halts after fetch
// - Breakpoint instruction with force enable halts
// - Memory breakpoint halts after causing instruction completes
// - Pipeline state gathered in one scan chain
// - Program counter captured at entry, restored by controller
// - Opcode image holds next opcode at entry
// - Scanned-in opcode executes on leaving debug
// - Exit control state captured, scanned-in value drives exit
// - Mode codes: run, low-power, debug, reserved
// - Flag cleared by test reset or release with leave
// - Hardware reset clears countdown
module dtc_debug_ctl
   import dtc_pkg::*;
(
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          reset_n,
   // Serial test port pins
   input  wire dtc_pins_s     test_pins,
   output logic               tdo_q,
   // Core handshake
   input  wire dtc_core_s     core_in,
   output dtc_core_ctl_s      core_ctl_q,
   // Restore image for the core on exit
   output logic        [63:0] restore_chain
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchroniser and edge detect
   dtc_pins_s pin_s1_q, pin_s2_q, pin_s3_q;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pin_s1_q <= '0;
         pin_s2_q <= '0;
         pin_s3_q <= '0;
      end else begin
         pin_s1_q <= test_pins;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   logic tck_rise, cap_rise, upd_rise, test_reset;
   assign tck_rise   = pin_s2_q.tck & ~pin_s3_q.tck;
   assign cap_rise   = pin_s2_q.capture & ~pin_s3_q.capture;
   assign upd_rise   = pin_s2_q.update & ~pin_s3_q.update;
   assign test_reset = ~pin_s2_q.trst_n;

   // Right-align the last w bits shifted in
   function automatic logic [63:0] take_field(input logic [63:0] sr, input logic [6:0] w);
      take_field = sr >> (LEN_SHIFT - w);
   endfunction : take_field

   ////////////////////////////////////////////////////////////////////////////
   // Shift register and port register writes
   logic [63:0] sr_q, sr_d, chain_q;
   logic [3:0]  ctrl_q, ctrl_d;
   logic        tdo_d, load_cnt, load_chain, go_cmd, ex_cmd;
   logic [15:0] cnt_q;
   logic        to_q;
   logic [1:0]  mode_q;

   // Register fields right-aligned from the shift register
   logic [63:0] fld_cnt, fld_ctrl, fld_cmd, fld_chain;
   assign fld_cnt   = take_field(sr_q, LEN_CNT);
   assign fld_ctrl  = take_field(sr_q, LEN_CTRL);
   assign fld_cmd   = take_field(sr_q, LEN_CMD);
   assign fld_chain = take_field(sr_q, LEN_CHAIN);

   always_comb begin
      sr_d       = sr_q;
      ctrl_d     = ctrl_q;
      load_cnt   = 1'b0;
      load_chain = 1'b0;
      go_cmd     = 1'b0;
      ex_cmd     = 1'b0;
      if (cap_rise) begin
         unique case (pin_s2_q.sel)
            SEL_CNT:   sr_d = {48'h0, cnt_q};
            SEL_CTRL:  sr_d = {60'h0, ctrl_q};
            SEL_STAT:  sr_d = {61'h0, mode_q, to_q};
            SEL_CHAIN: sr_d = chain_q;
            default:   sr_d = 64'h0;
         endcase
      end else if (tck_rise && pin_s2_q.shift) begin
         sr_d = {pin_s2_q.tdi, sr_q[63:1]};
      end
      if (upd_rise) begin
         unique case (pin_s2_q.sel)
            SEL_CNT:   load_cnt = 1'b1;
            SEL_CTRL:  ctrl_d = fld_ctrl[3:0];
            SEL_CHAIN: load_chain = 1'b1;
            SEL_CMD: begin
               go_cmd = fld_cmd[CMD_GO];
               ex_cmd = fld_cmd[CMD_EX];
            end
            default: ;
         endcase
      end
      tdo_d = sr_d[0];
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sr_q   <= 64'h0;
         ctrl_q <= CTRL_RESET;
         tdo_q  <= 1'b0;
      end else begin
         sr_q   <= sr_d;
         ctrl_q <= ctrl_d;
         tdo_q  <= tdo_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Debug entry, trace countdown and status
   dtc_state_e state_q, state_d;
   logic [15:0] cnt_d;
   logic        armed_q, armed_d, mpend_q, mpend_d, to_d, enter_now, to_set, exec;
   logic        dr, fdb;
   dtc_core_ctl_s core_ctl_d;

   assign exec = core_in.retired & ~core_in.aborted;
   assign dr   = ctrl_q[CTRL_DR];
   assign fdb  = chain_q[CHAIN_CTL_LSB + CTL_FDB];

   always_comb begin
      state_d    = state_q;
      cnt_d      = cnt_q;
      armed_d    = armed_q;
      mpend_d    = mpend_q;
      enter_now  = 1'b0;
      to_set     = 1'b0;
      core_ctl_d = '0;
      if (state_q != ST_DEBUG) begin
         if (armed_q && exec) begin
            if (cnt_q == 16'h0) begin
               enter_now = 1'b1;
               to_set    = 1'b1;
            end else begin
               cnt_d = cnt_q - 16'h1;
            end
         end
         if (mpend_q && exec) begin
            enter_now = 1'b1;
         end
         if (core_in.mem_breakpoint_instruction && ctrl_q[CTRL_MBE]) begin
            mpend_d = 1'b1;
         end
         if (dr || (core_in.breakpoint_instruction_exec && fdb)) begin
            state_d = ST_PEND;
         end
         if (dr && core_in.low_power) begin
            core_ctl_d.wake = 1'b1;
         end
         if (state_q == ST_PEND && core_in.fetch_latched) begin
            enter_now = 1'b1;
         end
      end else if (go_cmd) begin
         state_d            = ST_RUN;
         core_ctl_d.resume  = 1'b1;
         armed_d = ctrl_q[CTRL_TME] && (cnt_q != 16'h0 || ctrl_q[CTRL_SEQ]);
      end
      if (core_in.core_reset) begin
         cnt_d   = CNT_RESET;
         armed_d = 1'b0;
         mpend_d = 1'b0;
         state_d = ST_RUN;
         enter_now = dr && (state_q != ST_DEBUG);
         to_set    = 1'b0;
      end
      if (enter_now) begin
         state_d = ST_DEBUG;
         armed_d = 1'b0;
         mpend_d = 1'b0;
      end
      if (state_q == ST_DEBUG && core_in.core_reset) begin
         state_d = ST_DEBUG;
      end
      if (load_cnt) begin
         cnt_d = fld_cnt[15:0];
      end
      to_d = to_set | (to_q & ~(test_reset | (go_cmd & ex_cmd & state_q == ST_DEBUG)));
      core_ctl_d.halt_req = (state_d == ST_DEBUG);
      if (state_d == ST_DEBUG) begin
         core_ctl_d.mode = MODE_DEBUG;
      end else if (core_in.low_power && !core_ctl_d.wake) begin
         core_ctl_d.mode = MODE_LOW;
      end else begin
         core_ctl_d.mode = MODE_RUN;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q    <= ST_RUN;
         cnt_q      <= CNT_RESET;
         armed_q    <= 1'b0;
         mpend_q    <= 1'b0;
         to_q       <= 1'b0;
         core_ctl_q <= '0;
      end else begin
         state_q    <= state_d;
         cnt_q      <= cnt_d;
         armed_q    <= armed_d;
         mpend_q    <= mpend_d;
         to_q       <= to_d;
         core_ctl_q <= core_ctl_d;
      end
   end

   assign mode_q = core_ctl_q.mode;

   ////////////////////////////////////////////////////////////////////////////
   // Scan chain
   dtc_scan_chain u_chain (
      .clk        (clk),
      .reset_n    (reset_n),
      .capture_en (enter_now),
      .cpu_pc     (core_in.pc),
      .cpu_opcode (core_in.opcode),
      .cpu_state  (core_in.state),
      .load_en    (load_chain),
      .load_data  (fld_chain),
      .chain_q    (chain_q)
   );

   assign restore_chain = chain_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   chk_trace_dec: assert property (
      state_q != ST_DEBUG && armed_q && exec && cnt_q != 16'h0
      && !load_cnt && !core_in.core_reset |=> cnt_q == $past(cnt_q) - 16'h1)
      else $error("trace countdown did not decrement");
   chk_trace_entry: assert property (
      state_q != ST_DEBUG && armed_q && exec && cnt_q == 16'h0 && !core_in.core_reset
      |=> state_q == ST_DEBUG && to_q && core_ctl_q.halt_req)
      else $error("trace expiry did not enter debug");
   chk_abort_hold: assert property (
      state_q != ST_DEBUG && core_in.retired && core_in.aborted && !mpend_q
      && state_q != ST_PEND && !load_cnt && !core_in.core_reset
      |=> cnt_q == $past(cnt_q) && state_q != ST_DEBUG)
      else $error("aborted instruction affected trace");
   chk_mode_debug: assert property (
      (state_q == ST_DEBUG) == (core_ctl_q.mode == MODE_DEBUG))
      else $error("mode field disagrees with debug state");
   chk_reset_entry: assert property (
      core_in.core_reset && dr |=> state_q == ST_DEBUG ##0 core_ctl_q.halt_req)
      else $error("debug request at reset did not halt");
   chk_fetch_halt: assert property (
      state_q == ST_PEND && core_in.fetch_latched && !core_in.core_reset
      |=> state_q == ST_DEBUG)
      else $error("pending request did not halt on fetch");
   chk_wake_req: assert property (
      state_q != ST_DEBUG && dr && core_in.low_power && !core_in.core_reset
      |=> core_ctl_q.wake)
      else $error("low-power request did not wake");
   chk_breakpoint_instruction_pend: assert property (
      state_q == ST_RUN && core_in.breakpoint_instruction_exec && fdb && !core_in.core_reset
      |=> state_q != ST_RUN)
      else $error("breakpoint instruction ignored");
   chk_pc_capture: assert property (
      enter_now && !load_chain |=> chain_q[31:0] == $past(core_in.pc))
      else $error("program counter not captured at entry");
   chk_debug_hold: assert property (
      state_q == ST_DEBUG && !load_cnt && !core_in.core_reset |=> $stable(cnt_q))
      else $error("countdown moved in debug mode");
   chk_flag_clear: assert property (
      state_q == ST_DEBUG && go_cmd && ex_cmd |=> !to_q)
      else $error("trace flag not cleared on release");
   chk_op_capture: assert property (
      enter_now && !load_chain |=> chain_q[47:32] == $past(core_in.opcode))
      else $error("opcode image not captured at entry");
   chk_ctl_capture: assert property (
      enter_now && !load_chain |=> chain_q[63:48] == $past(core_in.state))
      else $error("exit control state not captured at entry");
   chk_mode_legal: assert property (
      core_ctl_q.mode != 2'h3)
      else $error("mode field shows reserved code");
   chk_release_run: assert property (
      state_q == ST_DEBUG && go_cmd && !core_in.core_reset
      |=> core_ctl_q.resume && !core_ctl_q.halt_req)
      else $error("release command did not resume");

   cov_trace_entry: cover property (armed_q && exec && cnt_q == 16'h0);
   cov_request:     cover property (state_q == ST_PEND ##[1:20] state_q == ST_DEBUG);
   cov_release:     cover property (state_q == ST_DEBUG && go_cmd);
   cov_mem_entry:   cover property (mpend_q && exec);
   cov_wake:        cover property (core_ctl_q.wake);

endmodule : dtc_debug_ctl
`default_nettype wire

// ---- logic/dtc_pkg.sv ----
// Package for the debug entry and trace control block.
// Holds the port register selects, the field layouts, the reset values and the shared types.
// Assumes one core clock. The test port pins reach the block asynchronously.
package dtc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Port register selects
   localparam logic [2:0] SEL_CNT   = 3'h0;
   localparam logic [2:0] SEL_CTRL  = 3'h1;
   localparam logic [2:0] SEL_STAT  = 3'h2;
   localparam logic [2:0] SEL_CHAIN = 3'h3;
   localparam logic [2:0] SEL_CMD   = 3'h4;

   // Shift lengths of each register
   localparam logic [6:0] LEN_CNT   = 7'h10;
   localparam logic [6:0] LEN_CTRL  = 7'h04;
   localparam logic [6:0] LEN_STAT  = 7'h03;
   localparam logic [6:0] LEN_CHAIN = 7'h40;
   localparam logic [6:0] LEN_CMD   = 7'h02;
   localparam logic [6:0] LEN_SHIFT = 7'h40;

   // debug_control_reg fields
   localparam int CTRL_DR  = 0;
   localparam int CTRL_TME = 1;
   localparam int CTRL_SEQ = 2;
   localparam int CTRL_MBE = 3;
   localparam logic [3:0] CTRL_RESET = 4'h0;

   // Command fields: release and leave-debug
   localparam int CMD_GO = 0;
   localparam int CMD_EX = 1;

   // cpu_scan_chain layout
   localparam int CHAIN_PC_LSB  = 0;
   localparam int CHAIN_OP_LSB  = 32;
   localparam int CHAIN_CTL_LSB = 48;
   localparam int CTL_FDB       = 7;
   localparam logic [63:0] CHAIN_RESET = 64'h0;

   // Processor mode field codes
   localparam logic [1:0] MODE_RUN   = 2'h0;
   localparam logic [1:0] MODE_LOW   = 2'h1;
   localparam logic [1:0] MODE_DEBUG = 2'h2;

   localparam logic [15:0] CNT_RESET = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [1:0] {ST_RUN, ST_PEND, ST_DEBUG} dtc_state_e;

   typedef struct packed {
      logic       tck;
      logic       tdi;
      logic       shift;
      logic       capture;
      logic       update;
      logic       trst_n;
      logic [2:0] sel;
   } dtc_pins_s;

   typedef struct packed {
      logic        core_reset;
      logic        retired;
      logic        aborted;
      logic        fetch_latched;
      logic        low_power;
      logic        breakpoint_instruction_exec;
      logic        mem_breakpoint_instruction;
      logic [31:0] pc;
      logic [15:0] opcode;
      logic [15:0] state;
   } dtc_core_s;

   typedef struct packed {
      logic       halt_req;
      logic       wake;
      logic       resume;
      logic [1:0] mode;
   } dtc_core_ctl_s;

endpackage : dtc_pkg

// ---- logic/dtc_scan_chain.sv ----
// Pipeline state scan chain: saved program counter, next opcode image, exit control state.
// Assumes capture and load strobes come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module dtc_scan_chain
   import dtc_pkg::*;
(
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        reset_n,
   // Capture from core at debug entry
   input  wire logic        capture_en,
   input  wire logic [31:0] cpu_pc,
   input  wire logic [15:0] cpu_opcode,
   input  wire logic [15:0] cpu_state,
   // Load from the test port
   input  wire logic        load_en,
   input  wire logic [63:0] load_data,
   // Chain contents
   output logic      [63:0] chain_q
);

   logic [63:0] chain_d;

   always_comb begin
      chain_d = chain_q;
      if (load_en) begin
         chain_d = load_data;
      end else if (capture_en) begin
         chain_d = {cpu_state, cpu_opcode, cpu_pc};
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         chain_q <= CHAIN_RESET;
      end else begin
         chain_q <= chain_d;
      end
   end

endmodule : dtc_scan_chain
`default_nettype wire

// ---- sim/debug_entry_trace_control_bench.sv ----
// Bench for the debug entry and trace control block.
// Assumes the controller model and core strobes are paced by the core clock falling edge.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin err_count++; \
   $display("BAD %s exp %0h got %0h", nm, ex, gt); end end
module debug_entry_trace_control_bench import dtc_pkg::*;;
   localparam logic [5:0] RST = 6'h20, RET = 6'h10, ABT = 6'h18;
   localparam logic [5:0] FET = 6'h04, BKP = 6'h02, MEM = 6'h01;
   logic          clk = 1'b0;
   logic          reset_n = 1'b0;
   logic    [5:0] strb = 6'h00;
   logic          low_pw = 1'b0;
   logic   [63:0] cur_chain = '0;
   logic   [15:0] n;
   logic   [63:0] exp_rd[$];
   logic   [63:0] exp_halt[$];
   logic          halt_prev = 1'b0;
   int            err_count = 0;
   int            num_checks = 0;
   int            resumes = 0;
   wire dtc_pins_s     pins;
   wire logic          tdo_q;
   wire dtc_core_ctl_s ctl;
   wire logic   [63:0] restore_chain;
   wire logic   [63:0] rd_data;
   wire logic          rd_valid;
   wire dtc_core_s     core_in = {strb[5:2], low_pw, strb[1:0], cur_chain[31:0],
                                  cur_chain[47:32], cur_chain[63:48]};

   always #5 clk = ~clk;

   dtc_debug_ctl dut (.clk(clk), .reset_n(reset_n), .test_pins(pins), .tdo_q(tdo_q),
      .core_in(core_in), .core_ctl_q(ctl), .restore_chain(restore_chain));
   dtc_host_model host (.clk(clk), .tdo_q(tdo_q), .pins(pins), .rd_data(rd_data),
      .rd_valid(rd_valid));

   ////////////////////////////////////////////////////////////////////////////
   // Result watcher: scan reads and debug entries against the oldest note
   always @(posedge clk) begin
      halt_prev <= ctl.halt_req;
      if (ctl.resume === 1'b1) begin
         resumes++;
      end
      if (rd_valid === 1'b1 && exp_rd.size() > 0) begin
         `CHK("scan_read", exp_rd[0], rd_data)
         void'(exp_rd.pop_front());
      end
      if (ctl.halt_req === 1'b1 && halt_prev !== 1'b1) begin
         if (exp_halt.size() == 0) begin
            `CHK("unexpected_halt", 1'b0, 1'b1)
         end else begin
            `CHK("halt_chain", exp_halt[0], restore_chain)
            `CHK("halt_mode", MODE_DEBUG, ctl.mode)
            void'(exp_halt.pop_front());
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Drivers
   task automatic final_report();
      $display("checks %0d errors %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : final_report

   task automatic new_core();
      cur_chain = {$urandom(), $urandom()};
   endtask : new_core

   task automatic strobe(input logic [5:0] s, input logic halt);
      @(negedge clk);
      if (halt) begin
         exp_halt.push_back(cur_chain);
      end
      strb = s;
      @(negedge clk);
      strb = 6'h00;
      repeat (4) @(negedge clk);
   endtask : strobe

   task automatic wr(input logic [2:0] sel, input logic [6:0] len, input logic [63:0] d);
      host.xfer(sel, len, d, 1'b0);
   endtask : wr

   task automatic rd(input logic [2:0] sel, input logic [6:0] len, input logic [63:0] ex);
      exp_rd.push_back(ex);
      host.xfer(sel, len, ex, 1'b1);
   endtask : rd

   task automatic go(input logic [3:0] c, input logic [15:0] cnt, input logic [63:0] ch,
                     input logic [1:0] cmd);
      int rc;
      rc = resumes;
      wr(SEL_CNT, LEN_CNT, {48'h0, cnt});
      wr(SEL_CHAIN, LEN_CHAIN, ch);
      wr(SEL_CTRL, LEN_CTRL, {60'h0, c});
      wr(SEL_CMD, LEN_CMD, {62'h0, cmd});
      `CHK("halt_req", 1'b0, ctl.halt_req)
      `CHK("mode_run", MODE_RUN, ctl.mode)
      `CHK("restore", ch, restore_chain)
      `CHK("resume_pulses", rc + 1, resumes)
   endtask : go

   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   initial begin
      void'($urandom(32'h875A));
      repeat (20) @(negedge clk);
      reset_n = 1'b1;
      repeat (4) @(negedge clk);
      rd(SEL_CNT, LEN_CNT, 64'h0);
      wr(SEL_CTRL, LEN_CTRL, 64'h1);
      new_core();
      strobe(RST, 1'b1);
      rd(SEL_STAT, LEN_STAT, {61'h0, MODE_DEBUG, 1'b0});
      rd(SEL_CHAIN, LEN_CHAIN, cur_chain);
      for (int k = 0; k < 3; k++) begin
         n = (k == 0) ? 16'h1 : (k == 1) ? 16'($urandom_range(6, 2)) : 16'h0;
         go({1'b0, (k == 2), 2'b10}, n, {$urandom(), $urandom()}, 2'h3);
         if (k > 0) rd(SEL_STAT, LEN_STAT, 64'h0);
         new_core();
         strobe(ABT, 1'b0);
         for (int i = 0; i < int'(n); i++) strobe(RET, 1'b0);
         strobe(RET, 1'b1);
         rd(SEL_STAT, LEN_STAT, {61'h0, MODE_DEBUG, 1'b1});
      end
      wr(SEL_CNT, LEN_CNT, 64'h5);
      strobe(RET, 1'b0);
      rd(SEL_CNT, LEN_CNT, 64'h5);
      host.test_reset();
      rd(SEL_STAT, LEN_STAT, {61'h0, MODE_DEBUG, 1'b0});
      go(4'h0, 16'h0, {$urandom(), $urandom()}, 2'h1);
      wr(SEL_CTRL, LEN_CTRL, 64'h1);
      new_core();
      strobe(RET, 1'b0);
      strobe(FET, 1'b1);
      go(4'h0, 16'h0, {$urandom(), $urandom()}, 2'h1);
      low_pw = 1'b1;
      repeat (4) @(negedge clk);
      `CHK("mode_low", MODE_LOW, ctl.mode)
      wr(SEL_CTRL, LEN_CTRL, 64'h1);
      `CHK("wake", 1'b1, ctl.wake)
      low_pw = 1'b0;
      new_core();
      strobe(FET, 1'b1);
      go(4'h0, 16'h0, {$urandom(), $urandom()} | 64'h0080_0000_0000_0000, 2'h1);
      strobe(BKP, 1'b0);
      new_core();
      strobe(FET, 1'b1);
      go(4'h8, 16'h0, {$urandom(), $urandom()} & ~64'h0080_0000_0000_0000, 2'h1);
      new_core();
      strobe(MEM, 1'b0);
      strobe(RET, 1'b1);
      repeat (10) @(negedge clk);
      `CHK("halts_left", 0, exp_halt.size())
      `CHK("reads_left", 0, exp_rd.size())
      final_report();
   end

   // Watchdog: about 40000 cycles, well above the expected run
   initial begin
      #400_000;
      err_count++;
      final_report();
   end

endmodule : debug_entry_trace_control_bench
`default_nettype wire

// ---- sim/dtc_host_model.sv ----
// External debug controller model: drives the serial test port pins.
// Assumes the core clock is only used to pace pin changes; tck stands still between frames.
`timescale 1ns/100ps
`default_nettype none
module dtc_host_model
   import dtc_pkg::*;
(
   // Pacing clock and serial return
   input  wire logic        clk,
   input  wire logic        tdo_q,
   // Test port pins
   output var  dtc_pins_s   pins,
   // Read result, one-cycle valid
   output var  logic [63:0] rd_data,
   output var  logic        rd_valid
);

   initial begin
      pins = '0;
      pins.trst_n = 1'b1;
      rd_data = '0;
      rd_valid = 1'b0;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk);
   endtask : wait_clk

   ////////////////////////////////////////////////////////////////////////////
   // One frame: select, capture, shift LSB first, update
   task automatic xfer(input logic [2:0] sel, input logic [6:0] len,
                       input logic [63:0] din, input logic want);
      logic [63:0] got;
      got = '0;
      pins.sel = sel;
      wait_clk(4);
      pins.capture = 1'b1;
      wait_clk(8);
      pins.capture = 1'b0;
      pins.shift = 1'b1;
      for (int i = 0; i < int'(len); i++) begin
         pins.tdi = din[i];
         wait_clk(4);
         got[i] = tdo_q;
         pins.tck = 1'b1;
         wait_clk(4);
         pins.tck = 1'b0;
      end
      pins.shift = 1'b0;
      pins.tdi = ~pins.tdi;
      pins.update = 1'b1;
      wait_clk(8);
      pins.update = 1'b0;
      wait_clk(4);
      if (want) begin
         rd_data = got;
         rd_valid = 1'b1;
         wait_clk(1);
         rd_valid = 1'b0;
      end
   endtask : xfer

   // Test logic reset pulse
   task automatic test_reset();
      pins.trst_n = 1'b0;
      wait_clk(8);
      pins.trst_n = 1'b1;
      wait_clk(4);
   endtask : test_reset

endmodule : dtc_host_model
`default_nettype wire
